// [verilog/lcd_host_pkg.sv]
`default_nettype none

package lcd_host_pkg;

  // interface mode codes, {if_sel_hi, if_sel_lo}
  localparam logic [1:0] MODE_I2C = 2'h0;
  localparam logic [1:0] MODE_CSI = 2'h1;
  localparam logic [1:0] MODE_P8  = 2'h2;
  localparam logic [1:0] MODE_P4  = 2'h3;

  // serial bit counter landmarks
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_BYTE = 4'h8;
  localparam logic [3:0] CNT_ACK  = 4'h9;

  // first byte field positions
  localparam int ID_MSB = 7;
  localparam int ID_LSB = 2;
  localparam int SEL_POS = 1;
  localparam int RW_POS = 0;

  // nibble resync: consecutive zero instruction nibbles
  localparam logic [1:0] ZERO_LAST = 2'h3;
  localparam logic [3:0] NIB_ZERO  = 4'h0;

  // pin synchroniser layout
  localparam int PIN_W   = 15;
  localparam int P_HI    = 14;
  localparam int P_LO    = 13;
  localparam int P_SCL   = 12;
  localparam int P_SDA   = 11;
  localparam int P_CSN   = 10;
  localparam int P_EN    = 9;
  localparam int P_SEL   = 8;

  // values after reset
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [PIN_W-1:0] PIN_RST = 15'h1c00;  // clock, data, select idle high
  localparam logic        BUSY_RST = 1'b1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_DATA = 4'h4,
    ST_SKIP = 4'h8
  } ser_state_t;

endpackage

`default_nettype wire

// [verilog/pin_sync.sv]
`default_nettype none

module pin_sync #(
  parameter int                W   = 1,
  parameter logic [W-1:0]      RST = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // two flip-flops, first stage read only by second
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_reg <= RST;
      q_reg    <= RST;
    end
    else
    begin
      meta_reg <= d_in;
      q_reg    <= meta_reg;
    end
  end

  assign q_out = q_reg;

endmodule

`default_nettype wire

// [verilog/lcd_host_if.sv]
`default_nettype none

// Summary of operation
// - straps pick I2C, serial, 8-bit, 4-bit
// - I2C is receive-only slave, never transmits
// - start/stop: SDA edge while SCL high
// - address upper six bits match strap identifier
// - address bit 1 selects instruction or RAM
// - matching address acked by open-drain low
// - ack each good byte; master resends others
// - matched transfer takes bytes until stop
// - chip select falling starts, rising ends
// - serial start byte must match identifier
// - seventh bit register select, eighth zero
// - serial bytes arrive most significant first
// - serial instruction dropped while still busy
// - 8-bit mode strobes whole bytes on enable
// - 4-bit mode: upper nibble then lower
// - four zero instruction nibbles resync order
// - timing follows operating clock; host matches
// - busy and refusing while reset held

module lcd_host_if (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       if_sel_hi_in,
  input  wire logic       if_sel_lo_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       cs_n_in,
  input  wire logic       en_in,
  input  wire logic       reg_select_bit_in,
  input  wire logic [7:0] db_in,
  input  wire logic       exec_busy_in,
  output logic            busy_flag_out,
  output logic            wr_valid_out,
  output logic            wr_sel_out,
  output logic [7:0]      wr_data_out
);

  logic [lcd_host_pkg::PIN_W-1:0] pin_raw;
  logic [lcd_host_pkg::PIN_W-1:0] pin_s;
  logic [1:0]                     mode;
  logic                           scl_s;
  logic                           sda_s;
  logic                           cs_s;
  logic                           en_s;
  logic                           sel_s;
  logic [7:0]                     db_s;
  logic [5:0]                     ident;

  // pins from the host pass two flip-flops first
  assign pin_raw = {if_sel_hi_in, if_sel_lo_in, scl_in, sda_in,
                    cs_n_in, en_in, reg_select_bit_in, db_in};

  pin_sync #(
    .W   (lcd_host_pkg::PIN_W),
    .RST (lcd_host_pkg::PIN_RST)
  ) u_sync (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .d_in    (pin_raw),
    .q_out   (pin_s)
  );

  // synchronised pin views
  assign mode  = {pin_s[lcd_host_pkg::P_HI], pin_s[lcd_host_pkg::P_LO]};
  assign scl_s = pin_s[lcd_host_pkg::P_SCL];
  assign sda_s = pin_s[lcd_host_pkg::P_SDA];
  assign cs_s  = pin_s[lcd_host_pkg::P_CSN];
  assign en_s  = pin_s[lcd_host_pkg::P_EN];
  assign sel_s = pin_s[lcd_host_pkg::P_SEL];
  assign db_s  = pin_s[7:0];
  assign ident = db_s[5:0];      // identifier straps share data pins

  // mode decode from straps
  logic is_i2c;
  logic is_csi;
  logic is_p8;
  logic is_p4;
  logic serial;

  assign is_i2c = (mode == lcd_host_pkg::MODE_I2C);
  assign is_csi = (mode == lcd_host_pkg::MODE_CSI);
  assign is_p8  = (mode == lcd_host_pkg::MODE_P8);
  assign is_p4  = (mode == lcd_host_pkg::MODE_P4);
  assign serial = is_i2c | is_csi;

  // previous pin levels for edge finding
  logic scl_d_reg;
  logic scl_d_next;
  logic sda_d_reg;
  logic sda_d_next;
  logic cs_d_reg;
  logic cs_d_next;
  logic en_d_reg;
  logic en_d_next;
  logic busy_reg;
  logic busy_next;

  always_comb
  begin
    scl_d_next = scl_s;
    sda_d_next = sda_s;
    cs_d_next  = cs_s;
    en_d_next  = en_s;
    busy_next  = exec_busy_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      scl_d_reg <= 1'b1;                     // idle high, no false edge
      sda_d_reg <= 1'b1;
      cs_d_reg  <= 1'b1;
      en_d_reg  <= 1'b0;
      busy_reg  <= lcd_host_pkg::BUSY_RST;
    end
    else
    begin
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
      cs_d_reg  <= cs_d_next;
      en_d_reg  <= en_d_next;
      busy_reg  <= busy_next;
    end
  end

  // edge events
  logic scl_rise;
  logic scl_fall;
  logic start_i2c;
  logic stop_i2c;
  logic cs_fall;
  logic cs_rise;
  logic en_fall;

  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_i2c = is_i2c & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_i2c  = is_i2c & scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign cs_fall   = is_csi & cs_d_reg & ~cs_s;
  assign cs_rise   = is_csi & ~cs_d_reg & cs_s;
  assign en_fall   = en_d_reg & ~en_s;

  // serial receiver state
  lcd_host_pkg::ser_state_t state_reg;
  lcd_host_pkg::ser_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic       sel_bit_reg;
  logic       sel_bit_next;
  logic       ack_reg;
  logic       ack_next;

  // nibble assembly state
  logic       nib_lo_reg;
  logic       nib_lo_next;
  logic [3:0] nib_reg;
  logic [3:0] nib_next;
  logic [1:0] zero_cnt_reg;
  logic [1:0] zero_cnt_next;

  // write port toward the decoder
  logic       valid_reg;
  logic       valid_next;
  logic       wrs_reg;
  logic       wrs_next;
  logic [7:0] wdata_reg;
  logic [7:0] wdata_next;

  logic byte_done;
  logic id_match;
  logic instr_drop;

  // i2c closes a byte at the eighth falling SCL, serial at once
  assign byte_done  = (cnt_reg == lcd_host_pkg::CNT_BYTE) & (is_csi | scl_fall);
  assign id_match   = (shift_reg[lcd_host_pkg::ID_MSB:lcd_host_pkg::ID_LSB] == ident)
                      & ~shift_reg[lcd_host_pkg::RW_POS];
  assign instr_drop = ~sel_bit_reg & busy_reg;

  // receive sequencing for serial and parallel modes
  always_comb
  begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    sel_bit_next  = sel_bit_reg;
    ack_next      = ack_reg;
    nib_lo_next   = nib_lo_reg;
    nib_next      = nib_reg;
    zero_cnt_next = zero_cnt_reg;
    valid_next    = 1'b0;
    wrs_next      = wrs_reg;
    wdata_next    = wdata_reg;
    if (start_i2c || cs_fall)
    begin
      state_next = lcd_host_pkg::ST_ADDR;
      cnt_next   = lcd_host_pkg::CNT_ZERO;
      ack_next   = 1'b0;
    end
    else if (stop_i2c || cs_rise || !serial)
    begin
      state_next = lcd_host_pkg::ST_IDLE;
      cnt_next   = lcd_host_pkg::CNT_ZERO;
      ack_next   = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        lcd_host_pkg::ST_IDLE:
        begin
          cnt_next = lcd_host_pkg::CNT_ZERO;
        end
        lcd_host_pkg::ST_ADDR,
        lcd_host_pkg::ST_DATA,
        lcd_host_pkg::ST_SKIP:
        begin
          // shift in msb first on rising clock
          if (scl_rise && cnt_reg < lcd_host_pkg::CNT_BYTE)
          begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = cnt_reg + 4'h1;
          end
          // release the ack after the ninth clock
          if (scl_fall && cnt_reg == lcd_host_pkg::CNT_ACK)
          begin
            ack_next = 1'b0;
            cnt_next = lcd_host_pkg::CNT_ZERO;
          end
          if (byte_done)
          begin
            cnt_next = is_i2c ? lcd_host_pkg::CNT_ACK : lcd_host_pkg::CNT_ZERO;
            if (state_reg == lcd_host_pkg::ST_ADDR)
            begin
              if (id_match)
              begin
                sel_bit_next = shift_reg[lcd_host_pkg::SEL_POS];
                state_next  = lcd_host_pkg::ST_DATA;
                ack_next    = is_i2c;
              end
              else
              begin
                state_next = lcd_host_pkg::ST_SKIP;
              end
            end
            else if (state_reg == lcd_host_pkg::ST_DATA && !instr_drop)
            begin
              valid_next = 1'b1;
              wrs_next   = sel_bit_reg;
              wdata_next = shift_reg;
              ack_next   = is_i2c;
            end
          end
        end
      endcase
    end
    // whole byte on the enable strobe
    if (is_p8 && en_fall)
    begin
      valid_next = 1'b1;
      wrs_next   = sel_s;
      wdata_next = db_s;
    end
    // two nibbles on the upper data lines
    if (is_p4 && en_fall)
    begin
      if (!nib_lo_reg)
      begin
        nib_next    = db_s[7:4];
        nib_lo_next = 1'b1;
      end
      else
      begin
        valid_next  = 1'b1;
        wrs_next    = sel_s;
        wdata_next  = {nib_reg, db_s[7:4]};
        nib_lo_next = 1'b0;
      end
      if (!sel_s && db_s[7:4] == lcd_host_pkg::NIB_ZERO)
      begin
        if (zero_cnt_reg == lcd_host_pkg::ZERO_LAST)
        begin
          zero_cnt_next = 2'h0;
          nib_lo_next   = 1'b0;
        end
        else
        begin
          zero_cnt_next = zero_cnt_reg + 2'h1;
        end
      end
      else
      begin
        zero_cnt_next = 2'h0;
      end
    end
    if (!is_p4)
    begin
      nib_lo_next   = 1'b0;
      zero_cnt_next = 2'h0;
    end
  end

  // ack held off under reset
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg    <= lcd_host_pkg::ST_IDLE;
      cnt_reg      <= lcd_host_pkg::CNT_ZERO;
      shift_reg    <= lcd_host_pkg::BYTE_RST;
      sel_bit_reg  <= 1'b0;
      ack_reg      <= 1'b0;
      nib_lo_reg   <= 1'b0;
      nib_reg      <= 4'h0;
      zero_cnt_reg <= 2'h0;
      valid_reg    <= 1'b0;
      wrs_reg      <= 1'b0;
      wdata_reg    <= lcd_host_pkg::BYTE_RST;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      shift_reg    <= shift_next;
      sel_bit_reg  <= sel_bit_next;
      ack_reg      <= ack_next;
      nib_lo_reg   <= nib_lo_next;
      nib_reg      <= nib_next;
      zero_cnt_reg <= zero_cnt_next;
      valid_reg    <= valid_next;
      wrs_reg      <= wrs_next;
      wdata_reg    <= wdata_next;
    end
  end

  // open-drain: only ever pulls low
  assign sda_out       = 1'b0;
  assign sda_oe_out    = ack_reg;
  assign busy_flag_out = busy_reg;
  assign wr_valid_out  = valid_reg;
  assign wr_sel_out    = wrs_reg;
  assign wr_data_out   = wdata_reg;

  // checks on the receive behaviour
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  serial_only_mode_a: assert property (
    state_reg != lcd_host_pkg::ST_IDLE |-> serial)
    else $error("serial state active outside serial mode");

  ack_only_i2c_a: assert property (
    sda_oe_out |-> is_i2c && state_reg != lcd_host_pkg::ST_IDLE)
    else $error("sda driven outside i2c transfer");

  start_enters_a: assert property (
    start_i2c |=> state_reg == lcd_host_pkg::ST_ADDR && cnt_reg == lcd_host_pkg::CNT_ZERO)
    else $error("start did not open address phase");

  stop_ends_a: assert property (
    stop_i2c |=> state_reg == lcd_host_pkg::ST_IDLE && !sda_oe_out)
    else $error("stop did not end transfer");

  addr_ack_a: assert property (
    is_i2c && state_reg == lcd_host_pkg::ST_ADDR && byte_done && id_match
    |=> sda_oe_out && state_reg == lcd_host_pkg::ST_DATA)
    else $error("matching address not acknowledged");

  select_capture_a: assert property (
    state_reg == lcd_host_pkg::ST_ADDR && byte_done && id_match
    |=> sel_bit_reg == $past(shift_reg[lcd_host_pkg::SEL_POS]))
    else $error("register select not taken from address");

  mismatch_skip_a: assert property (
    state_reg == lcd_host_pkg::ST_ADDR && byte_done && !id_match
    |=> state_reg == lcd_host_pkg::ST_SKIP && !sda_oe_out)
    else $error("mismatched address not ignored");

  ack_release_a: assert property (
    sda_oe_out && scl_fall && cnt_reg == lcd_host_pkg::CNT_ACK && !start_i2c
    |=> !sda_oe_out)
    else $error("ack held past ninth clock");

  cs_start_a: assert property (
    cs_fall |=> state_reg == lcd_host_pkg::ST_ADDR)
    else $error("chip select fall did not start transfer");

  msb_first_a: assert property (
    state_reg != lcd_host_pkg::ST_IDLE && scl_rise && cnt_reg < lcd_host_pkg::CNT_BYTE
    && !start_i2c && !stop_i2c && !cs_fall && !cs_rise
    |=> shift_reg[0] == $past(sda_s) && shift_reg[7:1] == $past(shift_reg[6:0]))
    else $error("bit not shifted msb first");

  busy_drop_a: assert property (
    serial && state_reg == lcd_host_pkg::ST_DATA && byte_done && instr_drop
    |=> !wr_valid_out && !sda_oe_out)
    else $error("instruction accepted while busy");

  p8_byte_a: assert property (
    is_p8 && en_fall
    |=> wr_valid_out && wr_data_out == $past(db_s) && wr_sel_out == $past(sel_s))
    else $error("parallel byte not delivered");

  nibble_pair_a: assert property (
    is_p4 && en_fall && nib_lo_reg
    |=> wr_valid_out && wr_data_out[7:4] == $past(nib_reg))
    else $error("nibble pair misassembled");

  nibble_sync_a: assert property (
    is_p4 && en_fall && !sel_s && db_s[7:4] == lcd_host_pkg::NIB_ZERO
    && zero_cnt_reg == lcd_host_pkg::ZERO_LAST |=> !nib_lo_reg)
    else $error("fourth zero nibble did not resync");

endmodule

`default_nettype wire

// [tb/host_model.sv]
`default_nettype none

// host side: drives the serial pins, the chip select and the parallel bus
module host_model (
  input  wire logic       clk_in,
  input  wire logic [5:0] ident_in,
  input  wire logic       sda_line_in,
  output logic            scl_out,
  output logic            sda_low_out,
  output logic            cs_n_out,
  output logic            en_out,
  output logic            reg_select_bit_out,
  output logic [7:0]      db_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels; link clock stands still outside frames
  initial
  begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
    cs_n_out    = 1'b1;
    en_out      = 1'b0;
    reg_select_bit_out = 1'b0;
    db_out      = 8'h00;
  end

  // five falling edges make half of the 80 ns link period
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // data changes only while the link clock is low
  task automatic bit_out(input logic v);
    scl_out = 1'b0;
    tick(2);
    sda_low_out = ~v;
    tick(3);
    scl_out = 1'b1;
    tick(5);
  endtask

  // msb first, one byte at the link rate
  task automatic byte_out(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
  endtask

  // start: data falls while the clock is high; identifier on the straps
  task automatic i2c_start();
    db_out      = {2'h0, ident_in};
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
    tick(5);
    sda_low_out = 1'b1;
    tick(5);
  endtask

  // byte plus ninth clock; line released so only the device can pull it
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    byte_out(b);
    scl_out = 1'b0;
    tick(2);
    sda_low_out = 1'b0;
    tick(3);
    scl_out = 1'b1;
    tick(4);
    ack = ~sda_line_in;
    tick(1);
  endtask

  // stop: data rises while the clock is high
  task automatic i2c_stop();
    scl_out = 1'b0;
    tick(2);
    sda_low_out = 1'b1;
    tick(3);
    scl_out = 1'b1;
    tick(5);
    sda_low_out = 1'b0;
    tick(5);
  endtask

  // framed by chip select: start byte then nbits of body, msb first
  task automatic ser_frame(input logic [7:0] start, input logic [15:0] body, input int nbits);
    db_out   = {2'h0, ident_in};
    cs_n_out = 1'b0;
    tick(5);
    byte_out(start);
    for (int i = 15; i >= 16 - nbits; i--) bit_out(body[i]);
    tick(5);
    cs_n_out    = 1'b1;
    sda_low_out = 1'b0;
    tick(5);
  endtask

  // enable strobe; bus shows the inverse once released
  task automatic par_wr(input logic sel, input logic [7:0] d);
    reg_select_bit_out = sel;
    db_out = d;
    tick(2);
    en_out = 1'b1;
    tick(5);
    en_out = 1'b0;
    tick(5);
    db_out = ~d;
    reg_select_bit_out = ~sel;
    tick(1);
  endtask
endmodule

`default_nettype wire

// [tb/testbench.sv]
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [5:0] ident = 6'h2d; // arbitrary strap identifier

  logic       clk_in;
  logic       rstn_in;
  logic       if_sel_hi;
  logic       if_sel_lo;
  logic       exec_busy;
  logic       scl;
  logic       sda_low;
  logic       cs_n;
  logic       en;
  logic       reg_select_bit;
  logic [7:0] db;
  logic       sda_out;
  logic       sda_oe;
  logic       busy_flag;
  logic       wr_valid;
  logic       wr_sel;
  logic [7:0] wr_data;
  wire        sda_line;
  logic [8:0] exp_q[$];
  int         err_total;
  int         checks_done;
  int         seed;
  logic [7:0] d;
  logic [7:0] d2;
  logic       ack;

  // pull-up line, pulled low by either party
  assign sda_line = ~sda_low & ~(sda_oe & ~sda_out);

  initial clk_in = 1'b0;
  always #4 clk_in = ~clk_in;

  lcd_host_if dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .if_sel_hi_in(if_sel_hi), .if_sel_lo_in(if_sel_lo),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe),
    .cs_n_in(cs_n), .en_in(en), .reg_select_bit_in(reg_select_bit), .db_in(db),
    .exec_busy_in(exec_busy), .busy_flag_out(busy_flag), .wr_valid_out(wr_valid),
    .wr_sel_out(wr_sel), .wr_data_out(wr_data)
  );

  host_model host (
    .clk_in(clk_in), .ident_in(ident), .sda_line_in(sda_line), .scl_out(scl),
    .sda_low_out(sda_low), .cs_n_out(cs_n), .en_out(en),
    .reg_select_bit_out(reg_select_bit), .db_out(db)
  );

  // counted compare
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic wrap_up();
    if (exp_q.size() != 0)
    begin
      err_total++;
      $display("mismatch at %0t: %0d bytes never delivered", $time, exp_q.size());
    end
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // strap change, then let the synchronisers settle
  task automatic set_mode(input logic [1:0] m);
    {if_sel_hi, if_sel_lo} = m;
    host.tick(10);
  endtask

  // one i2c byte with the expected acknowledge and delivery
  task automatic i2c_b(input logic [7:0] b, input logic want, input logic rsb, input logic keep);
    if (keep)
      exp_q.push_back({rsb, b});
    host.i2c_byte(b, ack);
    chk({8'h00, ack}, {8'h00, want});
  endtask

  // upper nibble then lower on the 4-bit bus
  task automatic p4_byte(input logic rsb, input logic [7:0] b);
    exp_q.push_back({rsb, b});
    host.par_wr(rsb, {b[7:4], 4'h0});
    host.par_wr(rsb, {b[3:0], 4'h0});
  endtask

  // each delivered byte takes the oldest note off the queue
  always @(negedge clk_in)
  begin
    if (wr_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk({wr_sel, wr_data}, 9'h1ff ^ {wr_sel, wr_data});
      else
        chk({wr_sel, wr_data}, exp_q.pop_front());
    end
  end

  // hang guard
  initial
  begin
    #300us;
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end

  // main sequence
  initial
  begin
    seed      = 26339;
    rstn_in   = 1'b0;
    exec_busy = 1'b0;
    if_sel_hi = 1'b0;
    if_sel_lo = 1'b0;
    repeat (2) @(negedge clk_in);
    chk({6'h00, wr_valid, busy_flag, sda_oe}, 9'h002);
    repeat (3) @(negedge clk_in);
    rstn_in = 1'b1;
    $display("test reset done");

    set_mode(lcd_host_pkg::MODE_I2C);
    d  = $random(seed);
    d2 = $random(seed);
    host.i2c_start();
    i2c_b({ident, 2'b00}, 1'b1, 1'b0, 1'b0);
    i2c_b(d, 1'b1, 1'b0, 1'b1);
    exec_busy = 1'b1;
    i2c_b(d2, 1'b0, 1'b0, 1'b0);
    exec_busy = 1'b0;
    i2c_b(d2, 1'b1, 1'b0, 1'b1);
    host.i2c_stop();
    host.i2c_start();
    i2c_b({ident, 2'b10}, 1'b1, 1'b1, 1'b0);
    exec_busy = 1'b1;
    i2c_b(d, 1'b1, 1'b1, 1'b1);
    exec_busy = 1'b0;
    host.i2c_stop();
    host.i2c_start();
    i2c_b({ident ^ 6'h01, 2'b00}, 1'b0, 1'b0, 1'b0);
    i2c_b(d, 1'b0, 1'b0, 1'b0);
    host.i2c_stop();
    host.i2c_start();
    i2c_b({ident, 2'b01}, 1'b0, 1'b0, 1'b0);
    i2c_b(d2, 1'b0, 1'b0, 1'b0);
    host.i2c_stop();
    $display("test i2c done");

    set_mode(lcd_host_pkg::MODE_CSI);
    exp_q.push_back({1'b0, d});
    exp_q.push_back({1'b0, d2});
    host.ser_frame({ident, 2'b00}, {d, d2}, 16);
    exp_q.push_back({1'b1, d});
    host.ser_frame({ident, 2'b10}, {d, d2}, 12);
    host.ser_frame({ident ^ 6'h20, 2'b10}, {d, d2}, 16);
    host.ser_frame({ident, 2'b01}, {d, d2}, 8);
    exec_busy = 1'b1;
    host.ser_frame({ident, 2'b00}, {d, d2}, 8);
    chk({7'h00, busy_flag, sda_oe}, 9'h002);
    exec_busy = 1'b0;
    $display("test serial done");

    set_mode(lcd_host_pkg::MODE_P8);
    chk({8'h00, busy_flag}, 9'h000);
    for (int i = 0; i < 4; i++)
    begin
      d = $random(seed);
      exp_q.push_back({d[0], d});
      host.par_wr(d[0], d);
    end
    $display("test parallel8 done");

    set_mode(lcd_host_pkg::MODE_P4);
    d = $random(seed);
    p4_byte(1'b1, d);
    exp_q.push_back(9'h050);
    exp_q.push_back(9'h000);
    host.par_wr(1'b0, 8'h50);
    repeat (4) host.par_wr(1'b0, 8'h00);
    p4_byte(1'b0, d ^ 8'h3c);
    host.tick(10);
    $display("test parallel4 done");
    wrap_up();
  end
endmodule

`default_nettype wire
